/* bsms_top.sv */
// Boot strap capture, boot mode decode and pad steering.
// Straps and power-up enable arrive from board pins; all else is on
// the core clock. Reset is synchronous, active high.
`timescale 1ns/1ns

// Notes on behaviour
// [RQ1] Read straps at reset, then free the pins
// [RQ2] Strap a high: flash; both low: download
// [RQ3] Board never drives a low, b high
// [RQ4] Download mode enables USB serial, OTG, UART; OTG stays off when i_otg_dl_disable is high
// [RQ5] Board holds straps 3 ms after enable
// [RQ6] Pads use default mux or routing matrix
// [RQ7] Deep sleep: only always-on pads driven; o_otg_pad_oe is not gated by i_deep_sleep
// [RQ8] OTG download drives some pads after init
// [RQ9] OTG pads: three in, oen high, tx low
// [RQ10] Straps latched once, kept until reset
module bsms_top #(
   parameter logic [bsms_pkg::CNT_W-1:0] P_HOLD_CYC = bsms_pkg::HOLD_CYC
) (
   input  wire logic                          i_core_clk,
   input  wire logic                          i_reset,
   input  wire logic                          i_chip_power_up_enable,
   input  wire logic                          i_boot_select_strap_a,
   input  wire logic                          i_boot_select_strap_b,
   input  wire logic                          i_deep_sleep,
   input  wire logic                          i_otg_dl_disable,
   input  wire logic [bsms_pkg::PADS-1:0]     i_mux_out,
   input  wire logic [bsms_pkg::PADS-1:0]     i_mux_oe,
   input  wire logic [bsms_pkg::PADS-1:0]     i_matrix_sel,
   input  wire logic [bsms_pkg::PADS-1:0]     i_matrix_out,
   input  wire logic [bsms_pkg::PADS-1:0]     i_matrix_oe,
   output logic      [1:0]                    o_boot_mode,
   output logic                               o_mode_valid,
   output logic                               o_straps_released,
   output logic                               o_dl_usb_serial_en,
   output logic                               o_dl_usb_otg_en,
   output logic                               o_dl_uart_en,
   output logic      [bsms_pkg::PADS-1:0]     o_pad_out,
   output logic      [bsms_pkg::PADS-1:0]     o_pad_oe,
   output logic      [bsms_pkg::OTG_PADS-1:0] o_otg_pad_out,
   output logic      [bsms_pkg::OTG_PADS-1:0] o_otg_pad_oe
);

   // Synchroniser stages: bit 0 power-up, 1 strap a, 2 strap b
   logic [2:0]                    sync1_r;   // First stage only
   logic [2:0]                    sync2_r;   // Safe to read
   // Sequencer
   bsms_pkg::bsms_state_t         state_r;
   bsms_pkg::bsms_state_t         state_nxt;
   logic [bsms_pkg::CNT_W-1:0]    cnt_r;     // Cycles since enable seen high
   logic [bsms_pkg::CNT_W-1:0]    cnt_nxt;
   // Latched straps and decoded mode
   logic                          strap_a_r;
   logic                          strap_b_r;
   bsms_pkg::bsms_mode_t          mode_r;
   bsms_pkg::bsms_mode_t          mode_dec;
   logic                          valid_r;
   logic                          dl_serial_r;
   logic                          dl_otg_r;
   logic                          dl_uart_r;
   // Pad stage
   logic [bsms_pkg::PADS-1:0]     pad_out_r;
   logic [bsms_pkg::PADS-1:0]     pad_oe_r;
   logic [bsms_pkg::PADS-1:0]     pad_out_nxt;
   logic [bsms_pkg::PADS-1:0]     pad_oe_nxt;
   logic [bsms_pkg::OTG_PADS-1:0] otg_out_r;
   logic [bsms_pkg::OTG_PADS-1:0] otg_oe_r;

   // Decode wires
   wire logic                        pu_on      = sync2_r[0];
   wire logic [bsms_pkg::CNT_W-1:0]  capture_at = P_HOLD_CYC >> 1;
   wire logic [bsms_pkg::CNT_W-1:0]  hold_last  = P_HOLD_CYC - 1'b1;
   wire logic                        capture    = (state_r == bsms_pkg::BSMS_ST_HOLD)
                                                  && (cnt_r == capture_at);
   wire logic                        hold_end   = (state_r == bsms_pkg::BSMS_ST_HOLD)
                                                  && (cnt_r == hold_last);
   wire logic                        released   = (state_r == bsms_pkg::BSMS_ST_DONE);
   wire logic                        otg_active = released && dl_otg_r;

   // Two-flop synchronisers for the board pins
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         sync1_r <= 3'h0;
         sync2_r <= 3'h0;
      end
      else
      begin
         sync1_r <= {i_boot_select_strap_b, i_boot_select_strap_a, i_chip_power_up_enable};
         sync2_r <= sync1_r;
      end
   end

   // Sequencer next state: wait for enable, count window, done
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      unique case (state_r)
         // Waiting for the power-up enable to rise
         bsms_pkg::BSMS_ST_WAIT:
         begin
            cnt_nxt = '0;
            if (pu_on)
            begin
               state_nxt = bsms_pkg::BSMS_ST_HOLD;
            end
         end
         // Straps are held by the board during this window
         bsms_pkg::BSMS_ST_HOLD:
         begin
            cnt_nxt = cnt_r + 1'b1;
            if (hold_end)
            begin
               state_nxt = bsms_pkg::BSMS_ST_DONE;
            end
         end
         // Done: stays until the next reset
         bsms_pkg::BSMS_ST_DONE:
         begin
            cnt_nxt = cnt_r;
         end
         // Unused code falls back to waiting
         default:
         begin
            state_nxt = bsms_pkg::BSMS_ST_WAIT;
            cnt_nxt   = '0;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         state_r <= bsms_pkg::BSMS_ST_WAIT;
         cnt_r   <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // [RQ2] Mode decode from live straps
   // Strap a high wins; a low with b high is the forbidden case
   assign mode_dec = sync2_r[1] ? bsms_pkg::BSMS_MODE_FLASH :
                     (sync2_r[2] ? bsms_pkg::BSMS_MODE_INVALID
                                 : bsms_pkg::BSMS_MODE_DOWNLOAD);

   // [RQ10] One-time strap capture
   // [RQ1] Mode taken inside the window, [RQ5] before pins are freed
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         strap_a_r   <= 1'b0;
         strap_b_r   <= 1'b0;
         mode_r      <= bsms_pkg::BSMS_MODE_NONE;
         valid_r     <= 1'b0;
         dl_serial_r <= 1'b0;
         dl_otg_r    <= 1'b0;
         dl_uart_r   <= 1'b0;
      end
      else if (capture)
      begin
         strap_a_r   <= sync2_r[1];
         strap_b_r   <= sync2_r[2];
         mode_r      <= mode_dec;
         valid_r     <= 1'b1;
         // [RQ4] Serial and UART open in download mode; OTG too unless i_otg_dl_disable
         dl_serial_r <= (mode_dec == bsms_pkg::BSMS_MODE_DOWNLOAD);
         dl_otg_r    <= (mode_dec == bsms_pkg::BSMS_MODE_DOWNLOAD) && !i_otg_dl_disable;
         dl_uart_r   <= (mode_dec == bsms_pkg::BSMS_MODE_DOWNLOAD);
      end
   end

   // Per-pad steering
   genvar k;
   generate
      for (k = 0; k < bsms_pkg::PADS; k = k + 1)
      begin : g_pad
         // [RQ6] Matrix overrides the default mux
         wire logic sel_out = i_matrix_sel[k] ? i_matrix_out[k] : i_mux_out[k];
         wire logic sel_oe  = i_matrix_sel[k] ? i_matrix_oe[k]  : i_mux_oe[k];
         // Strap pads stay inputs until the window ends
         wire logic is_strap = (k == bsms_pkg::STRAP_A_IDX) || (k == bsms_pkg::STRAP_B_IDX);
         // [RQ7] Non always-on pads lose control in deep sleep
         wire logic asleep   = i_deep_sleep && !bsms_pkg::AON_MASK[k];
         assign pad_out_nxt[k] = sel_out;
         assign pad_oe_nxt[k]  = sel_oe && !asleep && (released || !is_strap);
      end
   endgenerate

   // Pad output flops
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         pad_out_r <= '0;
         pad_oe_r  <= '0;
         otg_out_r <= '0;
         otg_oe_r  <= '0;
      end
      else
      begin
         pad_out_r <= pad_out_nxt;
         pad_oe_r  <= pad_oe_nxt;
         // [RQ8] [RQ9] Transceiver pads set after release in OTG download
         otg_out_r <= otg_active ? bsms_pkg::OTG_LEVELS  : '0;
         otg_oe_r  <= otg_active ? bsms_pkg::OTG_OE_MASK : '0;
      end
   end

   // Outputs
   assign o_boot_mode        = mode_r;
   assign o_mode_valid       = valid_r;
   assign o_straps_released  = released;
   assign o_dl_usb_serial_en = dl_serial_r;
   assign o_dl_usb_otg_en    = dl_otg_r;
   assign o_dl_uart_en       = dl_uart_r;
   assign o_pad_out          = pad_out_r;
   assign o_pad_oe           = pad_oe_r;
   assign o_otg_pad_out      = otg_out_r;
   assign o_otg_pad_oe       = otg_oe_r;

   // Checks
   a_mode_flash_sel: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RQ2]
      valid_r && strap_a_r |-> mode_r == bsms_pkg::BSMS_MODE_FLASH)
      else $error("strap a high did not give flash boot");
   a_mode_dl_sel: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RQ2]
      capture && !sync2_r[1] && !sync2_r[2] |=> mode_r == bsms_pkg::BSMS_MODE_DOWNLOAD)
      else $error("both straps low did not give download boot");
   a_latch_held: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RQ10]
      valid_r |=> valid_r && $stable(mode_r) && $stable(strap_a_r) && $stable(strap_b_r))
      else $error("latched straps changed before reset");
   a_capture_in_window: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RQ5]
      $rose(valid_r) |-> state_r == bsms_pkg::BSMS_ST_HOLD && cnt_r == capture_at + 1'b1)
      else $error("straps captured outside the hold window");
   a_release_timing: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RQ1]
      hold_end |=> released ##1 released)
      else $error("strap pins not freed at end of window");
   a_strap_pad_in: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RQ1]
      !released ##1 !released |-> !pad_oe_r[bsms_pkg::STRAP_A_IDX]
                                  && !pad_oe_r[bsms_pkg::STRAP_B_IDX])
      else $error("strap pad driven during the window");
   a_sleep_release: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RQ7]
      i_deep_sleep |=> (pad_oe_r & ~bsms_pkg::AON_MASK) == '0)
      else $error("non always-on pad driven in deep sleep");
   a_matrix_route: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RQ6]
      released && !i_deep_sleep && i_matrix_sel[2] |=> o_pad_out[2] == $past(i_matrix_out[2]))
      else $error("routing matrix not steering pad");
   a_dl_routes: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RQ4]
      mode_r == bsms_pkg::BSMS_MODE_DOWNLOAD |-> dl_uart_r && dl_serial_r)
      else $error("download routes not enabled");
   a_otg_pad_levels: assert property (@(posedge i_core_clk) disable iff (i_reset) // [RQ9]
      otg_active |=> o_otg_pad_oe == 6'h38 && o_otg_pad_out == 6'h08)
      else $error("transceiver pads not set for OTG download");
   c_flash_boot: cover property (@(posedge i_core_clk) disable iff (i_reset)
      released && mode_r == bsms_pkg::BSMS_MODE_FLASH);
   c_dl_boot: cover property (@(posedge i_core_clk) disable iff (i_reset)
      otg_active ##1 o_otg_pad_oe != '0);
   c_invalid_boot: cover property (@(posedge i_core_clk) disable iff (i_reset)
      mode_r == bsms_pkg::BSMS_MODE_INVALID);

endmodule

/* bsms_pkg.sv */
// Constants and types for the boot strap mode selector.
// Assumes a 250 MHz core clock; long counts are overridable at the top.
package bsms_pkg;

   // Strap hold window after power-up enable, in ms
   localparam int T_HOLD_MS = 3;
   // Core clock rate in kHz (period 4 ns)
   localparam int CLK_KHZ   = 250000;
   // Counter width, wide enough for the hold window
   localparam int CNT_W     = 20;
   // Hold window in cycles; exact integer, so no rounding is needed
   localparam int HOLD_CYC_INT = T_HOLD_MS * CLK_KHZ;
   localparam logic [CNT_W-1:0] HOLD_CYC = CNT_W'(HOLD_CYC_INT);

   // Number of general pads and the always-on subset
   localparam int PADS = 8;
   localparam logic [PADS-1:0] AON_MASK = 8'h0f;
   // Pad positions of the two boot straps
   localparam int STRAP_A_IDX = 0;
   localparam int STRAP_B_IDX = 1;

   // Transceiver pads: 0 vp, 1 vm, 2 rcv in; 3 oen, 4 vpo, 5 vmo out
   localparam int OTG_PADS = 6;
   localparam logic [OTG_PADS-1:0] OTG_OE_MASK = 6'h38;
   localparam logic [OTG_PADS-1:0] OTG_LEVELS  = 6'h08;

   // Decoded boot mode
   typedef enum logic [1:0] {
      BSMS_MODE_NONE     = 2'h0,
      BSMS_MODE_FLASH    = 2'h1,
      BSMS_MODE_DOWNLOAD = 2'h2,
      BSMS_MODE_INVALID  = 2'h3
   } bsms_mode_t;

   // Capture sequencer
   typedef enum logic [1:0] {
      BSMS_ST_WAIT = 2'h0,
      BSMS_ST_HOLD = 2'h1,
      BSMS_ST_DONE = 2'h2
   } bsms_state_t;

endpackage

/* bsms_board.sv */
// Board model: strap resistors and the power-up enable switch.
// Runs on the bench clock so the strap hold window can be timed.
`timescale 1ns/1ns
module bsms_board #(
   parameter int P_HOLD = 40
) (
   input  wire logic i_core_clk,
   input  wire logic i_power_on,
   input  wire logic i_level_a,
   input  wire logic i_level_b,
   input  wire logic i_allow_bad,
   output logic      o_chip_power_up_enable,
   output logic      o_strap_a,
   output logic      o_strap_b
);
   int   held_r = 0;    // Cycles since enable rose
   logic tog_r  = 1'b0; // Pattern once pins are plain IO

   // Enable follows the power switch
   assign o_chip_power_up_enable = i_power_on;

   // Count the hold window while powered; plain always, as both
   // variables carry a start value in their declarations
   always @(posedge i_core_clk)
   begin
      held_r <= i_power_on ? held_r + 1 : 0;
      tog_r  <= ~tog_r;
   end

   always_comb
   begin
      if (held_r < P_HOLD + 8)
      begin
         o_strap_a = i_level_a;
         o_strap_b = i_level_b & (i_level_a | i_allow_bad);
      end
      else
      begin
         // Pins now plain IO, level changes every cycle
         o_strap_a = tog_r;
         o_strap_b = ~tog_r;
      end
   end
endmodule

/* bsms_top_test.sv */
// Self-checking bench for the boot strap mode selector.
// Board model drives straps and enable; pads are driven at random.
`timescale 1ns/1ns
module bsms_top_test;
   localparam int HOLD  = 40;   // Shortened hold window
   localparam int LIMIT = 2000; // Cycle ceiling
   typedef struct packed
   {
      logic [7:0] oe;
      logic [7:0] oe_m;
      logic [7:0] out;
      logic [7:0] out_m;
   } bsms_pnote_t;
   typedef logic [17:0] bsms_mnote_t; // Mode, valid, routes, OTG out, OTG oe
   logic        clk, rst, pwr, sa, sb, sleep, dis, pu, pa, pb;
   logic [7:0]  mo, moe, msel, xo, xoe, po, poe;
   logic [1:0]  mode;
   logic        valid, rel, ser, otg, uart;
   logic [5:0]  oo, ooe;
   int          errors, total_checks, cycles, seed, w;
   bsms_pnote_t pq[$];
   bsms_mnote_t mq[$];
   bsms_pnote_t pn;
   bsms_mnote_t mn;

   bsms_board #(.P_HOLD(HOLD)) i_bsms_board (.i_core_clk(clk), .i_power_on(pwr),
      .i_level_a(sa), .i_level_b(sb), .i_allow_bad(1'b1),
      .o_chip_power_up_enable(pu), .o_strap_a(pa), .o_strap_b(pb));
   bsms_top #(.P_HOLD_CYC(20'(HOLD))) i_bsms_top (.i_core_clk(clk), .i_reset(rst),
      .i_chip_power_up_enable(pu), .i_boot_select_strap_a(pa), .i_boot_select_strap_b(pb),
      .i_deep_sleep(sleep), .i_otg_dl_disable(dis), .i_mux_out(mo), .i_mux_oe(moe),
      .i_matrix_sel(msel), .i_matrix_out(xo), .i_matrix_oe(xoe), .o_boot_mode(mode),
      .o_mode_valid(valid), .o_straps_released(rel), .o_dl_usb_serial_en(ser),
      .o_dl_usb_otg_en(otg), .o_dl_uart_en(uart), .o_pad_out(po), .o_pad_oe(poe),
      .o_otg_pad_out(oo), .o_otg_pad_oe(ooe));

   // Clock, 4 ns period
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic tally_and_finish();
      $display("Checks %0d, errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic cmp_pad(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
      total_checks++;
      if ((got & m) !== (exp & m))
      begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got & m, exp & m);
      end
   endtask

   task automatic cmp_mode(input bsms_mnote_t got, input bsms_mnote_t exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Expected mode, routes and OTG pads for one strap set
   function automatic bsms_mnote_t exp_mode(input logic a, input logic b, input logic d);
      logic [1:0] m;
      logic       dl, og;
      m  = a ? 2'h1 : (b ? 2'h3 : 2'h2);
      dl = !a && !b;
      og = dl && !d;
      return {m, 1'b1, dl, og, dl, og ? bsms_pkg::OTG_LEVELS : 6'h00,
              og ? bsms_pkg::OTG_OE_MASK : 6'h00};
   endfunction

   // Random pad traffic; phase 0 held, 1 unsure, 2 released
   task automatic drive_pads(input logic [1:0] ph);
      bsms_pnote_t n;
      @(negedge clk);
      mo    = 8'($random(seed));
      moe   = 8'($random(seed));
      msel  = 8'($random(seed));
      xo    = 8'($random(seed));
      xoe   = 8'($random(seed));
      sleep = ($random(seed) & 3) == 0;
      n.out = (msel & xo) | (~msel & mo);
      n.oe  = (msel & xoe) | (~msel & moe);
      if (sleep)
         n.oe = n.oe & bsms_pkg::AON_MASK;
      if (ph == 2'd0)
         n.oe = n.oe & 8'hfc;
      n.oe_m  = (ph == 2'd1) ? 8'hfc : 8'hff;
      n.out_m = (ph == 2'd2) ? 8'hff : 8'hfc;
      if (sleep)
         n.out_m = n.out_m & bsms_pkg::AON_MASK;
      pq.push_back(n);
   endtask

   // Pad results one edge after each drive
   always @(posedge clk)
   begin
      #1;
      if (pq.size() > 0)
      begin
         pn = pq.pop_front();
         cmp_pad(poe, pn.oe, pn.oe_m);
         cmp_pad(po, pn.out, pn.out_m);
      end
   end

   // Mode result at release and again after strap pins wander
   always @(posedge rel)
   begin
      repeat (2) @(posedge clk);
      #1;
      mn = mq[0];
      cmp_mode({mode, valid, ser, otg, uart, oo, ooe}, mn);
      repeat (30) @(posedge clk);
      #1;
      cmp_mode({mode, valid, ser, otg, uart, oo, ooe}, mq.pop_front());
   end

   // Hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles >= LIMIT)
      begin
         errors++;
         tally_and_finish();
      end
   end

   initial
   begin
      {rst, pwr, sa, sb, sleep, dis} = 6'h20;
      {mo, moe, msel, xo, xoe} = 40'h0;
      errors = 0;
      total_checks = 0;
      cycles = 0;
      seed = 4927;
      // Every strap pair, OTG download allowed and forbidden
      for (int k = 0; k < 8; k++)
      begin
         @(negedge clk);
         rst = 1'b1;
         pwr = 1'b0;
         sa  = k[0];
         sb  = k[1];
         dis = k[2];
         repeat (5) @(negedge clk);
         rst = 1'b0;
         mq.push_back(exp_mode(sa, sb, dis));
         repeat (3) drive_pads(2'd0);
         pwr = 1'b1;
         repeat (HOLD - 2) drive_pads(2'd0);
         w = 0;
         while (rel !== 1'b1 && w < 20)
         begin
            drive_pads(2'd1);
            w++;
         end
         cmp_mode(18'(rel), 18'h1);
         drive_pads(2'd1);
         repeat (40) drive_pads(2'd2);
      end
      tally_and_finish();
   end
endmodule
